// ===== src/spbc_core.sv
// Byte count and DMA enable control for a serial port master
//
// Implementation choice: the address-and-strobe port.
`default_nettype none

module spbc_core (
    // Core clock and reset
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    // Link clock and shift engine
    input wire logic link_clk,
    input wire logic byte_shifted,
    output logic link_stop,
    // Register port
    input wire logic [spbc_pkg::SPBC_ADDR_W-1:0] reg_addr,
    input wire logic [spbc_pkg::SPBC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [spbc_pkg::SPBC_DATA_W-1:0] reg_rdata,
    // Port configuration from the rest of the port
    input wire logic master_mode,
    input wire logic multi_byte_frames,
    input wire logic port_enable,
    input wire logic [2:0] irq_threshold_field,
    // FIFO byte levels
    input wire logic [4:0] tx_fifo_bytes,
    input wire logic [4:0] rx_fifo_bytes,
    // Transfer status
    output logic frame_end,
    output logic xfer_done,
    output logic [spbc_pkg::SPBC_DATA_W-1:0] fifo_level_status,
    // DMA controller
    output logic tx_dma_req,
    output logic rx_dma_req,
    output logic tx_pad_byte,
    output logic rx_discard_byte
);
    import spbc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    spbc_link_if lk ();

    logic [15:0] transfer_byte_count_q;
    logic [2:0] dma_request_enable_q;
    logic [SPBC_COUNT_W-1:0] byte_total_field;
    logic repeat_frames_flag;
    logic tx_dma_request_enable;
    logic rx_dma_request_enable;

    logic [SPBC_COUNT_W-1:0] xfer_cnt_q;
    logic [SPBC_COUNT_W-1:0] xfer_cnt_d;
    logic [SPBC_COUNT_W-1:0] cnt_plus_one;
    spbc_state_type state_q;
    spbc_state_type state_d;

    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_s3_q;
    logic byte_evt;

    logic hit_cnt;
    logic hit_dma;
    logic hit_stat;
    logic cnt_written;
    logic counter_clear;
    logic counting;
    logic unlimited;
    logic repeat_on;
    logic count_reached;
    logic frame_end_d;
    logic stop_q;
    logic last_byte;
    logic [3:0] tx_units;
    logic [3:0] rx_units;
    logic [SPBC_DATA_W-1:0] stat_value;
    logic [SPBC_DATA_W-1:0] read_value;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    function automatic logic addr_is(input logic [SPBC_ADDR_W-1:0] addr,
                                     input logic [SPBC_ADDR_W-1:0] target);
        return addr == target;
    endfunction

    always_comb
    begin
        hit_cnt = 1'b0;
        hit_dma = 1'b0;
        hit_stat = 1'b0;
        if (addr_is(reg_addr, SPBC_CNT_ADDR))
            hit_cnt = 1'b1;
        else if (addr_is(reg_addr, SPBC_DMA_ADDR))
            hit_dma = 1'b1;
        else if (addr_is(reg_addr, SPBC_STAT_ADDR))
            hit_stat = 1'b1;
    end

    assign cnt_written = reg_wr && hit_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // Software registers

    // Byte count register; bit 14 is held at zero
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            transfer_byte_count_q <= SPBC_CNT_RESET;
        else if (ce && cnt_written)
        begin
            transfer_byte_count_q[SPBC_REPEAT_BIT] <= reg_wdata[SPBC_REPEAT_BIT];
            transfer_byte_count_q[SPBC_REPEAT_BIT-1] <= 1'b0;
            transfer_byte_count_q[SPBC_COUNT_W-1:0] <= reg_wdata[SPBC_COUNT_W-1:0];
        end
    end

    // DMA enable register; only the three low bits are stored
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            dma_request_enable_q <= SPBC_DMA_RESET;
        else if (ce && reg_wr && hit_dma)
            dma_request_enable_q <= reg_wdata[2:0];
    end

    assign byte_total_field = transfer_byte_count_q[SPBC_COUNT_W-1:0];
    assign repeat_frames_flag = transfer_byte_count_q[SPBC_REPEAT_BIT];
    assign tx_dma_request_enable = dma_request_enable_q[SPBC_DMA_TX_BIT];
    assign rx_dma_request_enable = dma_request_enable_q[SPBC_DMA_RX_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Byte event crossing from the link domain

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
        end
        else if (ce)
        begin
            tgl_s1_q <= lk.byte_tgl;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
        end
    end

    assign byte_evt = tgl_s2_q ^ tgl_s3_q;

    spbc_link_side u_link (
        .link_clk(link_clk),
        .nrst(nrst),
        .byte_shifted(byte_shifted),
        .link_stop(link_stop),
        .lk(lk)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transfer control

    // Counter is held clear outside master operation
    assign counter_clear = !port_enable || cnt_written || !master_mode;
    assign counting = (state_q == SPBC_RUN) && byte_evt;
    assign unlimited = (byte_total_field == '0);
    assign repeat_on = repeat_frames_flag && multi_byte_frames && !unlimited;
    assign cnt_plus_one = xfer_cnt_q + 14'h0001;
    assign count_reached = !unlimited && (cnt_plus_one == byte_total_field);
    assign last_byte = (state_q == SPBC_RUN) && !unlimited && (cnt_plus_one == byte_total_field);

    always_comb
    begin
        state_d = state_q;
        xfer_cnt_d = xfer_cnt_q;
        frame_end_d = 1'b0;
        if (counter_clear)
        begin
            state_d = SPBC_IDLE;
            xfer_cnt_d = '0;
        end
        else
        begin
            case (state_q)
                SPBC_IDLE:
                begin
                    state_d = SPBC_RUN;
                    xfer_cnt_d = '0;
                end
                SPBC_RUN:
                begin
                    if (counting)
                    begin
                        // Single-byte framing ends a frame on every byte
                        if (!multi_byte_frames)
                            frame_end_d = 1'b1;
                        if (unlimited)
                            xfer_cnt_d = cnt_plus_one;
                        else if (count_reached && repeat_on)
                        begin
                            frame_end_d = 1'b1;
                            xfer_cnt_d = '0;
                        end
                        else if (count_reached)
                        begin
                            frame_end_d = 1'b1;
                            xfer_cnt_d = cnt_plus_one;
                            state_d = SPBC_DONE;
                        end
                        else
                            xfer_cnt_d = cnt_plus_one;
                    end
                end
                SPBC_DONE:
                begin
                    state_d = SPBC_DONE;
                end
                default:
                begin
                    state_d = SPBC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            state_q <= SPBC_IDLE;
        else if (ce)
            state_q <= state_d;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            xfer_cnt_q <= '0;
        else if (ce)
            xfer_cnt_q <= xfer_cnt_d;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            frame_end <= 1'b0;
            xfer_done <= 1'b0;
        end
        else if (ce)
        begin
            frame_end <= frame_end_d;
            xfer_done <= (state_d == SPBC_DONE);
        end
    end

    // Stop level toward the shift engine, cleared while not master
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            stop_q <= 1'b0;
        else if (ce)
            stop_q <= (state_d == SPBC_DONE);
    end

    assign lk.stop = stop_q;

    ////////////////////////////////////////////////////////////////////////////
    // FIFO level report

    assign tx_units = spbc_units(tx_fifo_bytes, dma_request_enable_q[SPBC_DMA_EN_BIT]);
    assign rx_units = spbc_units(rx_fifo_bytes, dma_request_enable_q[SPBC_DMA_EN_BIT]);

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            fifo_level_status <= '0;
        else if (ce)
            fifo_level_status <= {4'h0, rx_units, 4'h0, tx_units};
    end

    ////////////////////////////////////////////////////////////////////////////
    // DMA requests

    spbc_dma_req u_dma (
        .clock(clock),
        .nrst(nrst),
        .ce(ce),
        .dma_ctrl({rx_dma_request_enable, tx_dma_request_enable, dma_request_enable_q[SPBC_DMA_EN_BIT]}),
        .irq_threshold_field(irq_threshold_field),
        .running(state_q != SPBC_DONE),
        .last_byte(last_byte),
        .odd_total(byte_total_field[0]),
        .tx_units(tx_units),
        .rx_units(rx_units),
        .tx_req(tx_dma_req),
        .rx_req(rx_dma_req),
        .tx_pad(tx_pad_byte),
        .rx_discard(rx_discard_byte)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    always_comb
    begin
        stat_value = '0;
        stat_value[SPBC_COUNT_W-1:0] = xfer_cnt_q;
        stat_value[SPBC_STAT_DONE_BIT] = (state_q == SPBC_DONE);
        stat_value[SPBC_STAT_RUN_BIT] = (state_q == SPBC_RUN);
    end

    always_comb
    begin
        read_value = '0;
        if (hit_cnt)
            read_value = transfer_byte_count_q;
        else if (hit_dma)
            read_value = {13'h0000, dma_request_enable_q};
        else if (hit_stat)
            read_value = stat_value;
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= '0;
        else if (ce)
            reg_rdata <= reg_rd ? read_value : '0;
    end
endmodule

`default_nettype wire

// ===== src/spbc_pkg.sv
// Constants, types and helpers shared by the byte count and DMA control block
// Notes on behaviour
// - The byte count register only acts while the port is master; in slave operation it does nothing.
// - A byte count of zero ignores the repeat flag and the master keeps going while its FIFOs are ready.
// - With multi-byte framing off, the repeat flag is ignored and every frame is one byte wide.
// - With the repeat flag clear, the master sends one frame of the programmed length and then stops.
// - With the repeat flag set, the master sends frames of the programmed length one after another.
// - A 14-bit count field holds the number of bytes for both receive and transmit.
// - A master transfer ends exactly when the programmed number of bytes has been shifted.
// - Half-word DMA with an odd count pads the last transmitted half word and drops the surplus received byte.
// - The internal byte counter is cleared when the port enable drops and whenever the count register is written.
// - Receive DMA requests are raised only while the receive request enable is set.
// - Transmit DMA requests are raised only while the transmit request enable is set.
// - Setting the DMA master enable starts DMA transfer and clearing it ends the DMA transfer.
// - FIFO levels are reported in half words while DMA is enabled, otherwise in bytes.
// - Receive DMA expects a zero threshold, so one unit present raises a request.
`default_nettype none

package spbc_pkg;

    localparam int SPBC_ADDR_W = 32;
    localparam int SPBC_DATA_W = 16;
    localparam int SPBC_COUNT_W = 14;

    localparam logic [31:0] SPBC_CNT_ADDR = 32'h4005_4018;
    localparam logic [31:0] SPBC_DMA_ADDR = 32'h4005_401C;
    localparam logic [31:0] SPBC_STAT_ADDR = 32'h4005_4040;

    localparam int SPBC_REPEAT_BIT = 15;
    localparam int SPBC_DMA_EN_BIT = 0;
    localparam int SPBC_DMA_TX_BIT = 1;
    localparam int SPBC_DMA_RX_BIT = 2;
    localparam int SPBC_STAT_DONE_BIT = 14;
    localparam int SPBC_STAT_RUN_BIT = 15;

    localparam logic [15:0] SPBC_CNT_RESET = 16'h0000;
    localparam logic [2:0] SPBC_DMA_RESET = 3'h0;
    localparam logic [3:0] SPBC_FIFO_UNITS = 4'h8;

    typedef enum logic [1:0] {
        SPBC_IDLE = 2'b00,
        SPBC_RUN = 2'b01,
        SPBC_DONE = 2'b10
    } spbc_state_type;

    // Converts a FIFO byte level into the reported unit, capped at full
    function automatic logic [3:0] spbc_units(input logic [4:0] bytes, input logic halfwords);
        logic [5:0] rounded;
        rounded = {1'b0, bytes} + 6'h01;
        if (halfwords)
            return (rounded[5:1] > 5'h08) ? SPBC_FIFO_UNITS : rounded[4:1];
        else
            return (bytes > 5'h08) ? SPBC_FIFO_UNITS : bytes[3:0];
    endfunction

endpackage

`default_nettype wire

// ===== src/spbc_link_if.sv
// Signals crossing between the core domain and the link domain
`default_nettype none

interface spbc_link_if;
    logic byte_tgl;
    logic stop;

    modport core (
        input byte_tgl,
        output stop
    );

    modport link (
        output byte_tgl,
        input stop
    );
endinterface

`default_nettype wire

// ===== src/spbc_link_side.sv
// Link-domain end: byte events as a toggle out, stop level synchronised in
`default_nettype none

module spbc_link_side (
    // Link clock and reset
    input wire logic link_clk,
    input wire logic nrst,
    // Shift engine
    input wire logic byte_shifted,
    output logic link_stop,
    // Crossing
    spbc_link_if.link lk
);
    import spbc_pkg::*;

    logic tgl_q;
    logic stop_s1_q;
    logic stop_s2_q;

    // One toggle per shifted byte, safe while the link clock stalls
    always_ff @(posedge link_clk or negedge nrst)
    begin
        if (!nrst)
            tgl_q <= 1'b0;
        else if (byte_shifted)
            tgl_q <= ~tgl_q;
    end

    always_ff @(posedge link_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stop_s1_q <= 1'b0;
            stop_s2_q <= 1'b0;
        end
        else
        begin
            stop_s1_q <= lk.stop;
            stop_s2_q <= stop_s1_q;
        end
    end

    assign lk.byte_tgl = tgl_q;
    assign link_stop = stop_s2_q;
endmodule

`default_nettype wire

// ===== src/spbc_dma_req.sv
// DMA request gating, odd-count padding and discard
`default_nettype none

module spbc_dma_req (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    // Control
    input wire logic [2:0] dma_ctrl,
    input wire logic [2:0] irq_threshold_field,
    input wire logic running,
    input wire logic last_byte,
    input wire logic odd_total,
    // FIFO levels in reported units
    input wire logic [3:0] tx_units,
    input wire logic [3:0] rx_units,
    // Requests
    output logic tx_req,
    output logic rx_req,
    output logic tx_pad,
    output logic rx_discard
);
    import spbc_pkg::*;

    logic dma_on;
    logic odd_tail;

    assign dma_on = dma_ctrl[SPBC_DMA_EN_BIT];
    assign odd_tail = dma_on && odd_total && last_byte;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_req <= 1'b0;
            rx_req <= 1'b0;
            tx_pad <= 1'b0;
            rx_discard <= 1'b0;
        end
        else if (ce)
        begin
            tx_req <= dma_on && dma_ctrl[SPBC_DMA_TX_BIT] && running && (tx_units < SPBC_FIFO_UNITS);
            rx_req <= dma_on && dma_ctrl[SPBC_DMA_RX_BIT] && ({1'b0, rx_units} > {2'b00, irq_threshold_field});
            tx_pad <= odd_tail;
            rx_discard <= odd_tail;
        end
    end
endmodule

`default_nettype wire

// ===== bench/spbc_core_chk.sv
// Checker for the byte count and DMA block
`default_nettype none

module spbc_core_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    // Register port
    input wire logic [spbc_pkg::SPBC_ADDR_W-1:0] reg_addr,
    input wire logic [spbc_pkg::SPBC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [spbc_pkg::SPBC_DATA_W-1:0] reg_rdata,
    // Configuration and status
    input wire logic master_mode,
    input wire logic port_enable,
    input wire logic [4:0] tx_fifo_bytes,
    input wire logic [4:0] rx_fifo_bytes,
    input wire logic frame_end,
    input wire logic xfer_done,
    input wire logic link_stop,
    input wire logic [spbc_pkg::SPBC_DATA_W-1:0] fifo_level_status,
    // DMA controller
    input wire logic tx_dma_req,
    input wire logic rx_dma_req,
    input wire logic tx_pad_byte,
    input wire logic rx_discard_byte
);
    import spbc_pkg::*;

    logic [15:0] cnt_q;
    logic [2:0] dma_q;
    logic [3:0] slave_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            cnt_q <= SPBC_CNT_RESET;
        else if (ce && reg_wr && reg_addr == SPBC_CNT_ADDR)
            cnt_q <= reg_wdata & 16'hBFFF;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            dma_q <= SPBC_DMA_RESET;
        else if (ce && reg_wr && reg_addr == SPBC_DMA_ADDR)
            dma_q <= reg_wdata[2:0];
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            slave_q <= 4'h0;
        else if (master_mode)
            slave_q <= 4'h0;
        else if (slave_q != 4'hF)
            slave_q <= slave_q + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_cnt_read;
        ce && reg_rd && reg_addr == SPBC_CNT_ADDR;
    endsequence

    sequence s_dma_read;
        ce && reg_rd && reg_addr == SPBC_DMA_ADDR;
    endsequence

    sequence s_cnt_write;
        ce && reg_wr && reg_addr == SPBC_CNT_ADDR;
    endsequence

    a_cnt_readback: assert property (s_cnt_read |=> reg_rdata == $past(cnt_q))
        else $error("count readback wrong");
    a_dma_readback: assert property (s_dma_read |=> reg_rdata == {13'h0000, $past(dma_q)})
        else $error("dma readback wrong");
    a_idle_read: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("stray read data");
    a_tx_gate: assert property (tx_dma_req |-> $past(dma_q[0] && dma_q[1]))
        else $error("tx req disabled");
    a_rx_gate: assert property (rx_dma_req |-> $past(dma_q[0] && dma_q[2]))
        else $error("rx req disabled");
    a_pad_gate: assert property (tx_pad_byte || rx_discard_byte |-> $past(dma_q[0]))
        else $error("pad without dma");
    a_byte_units: assert property (!$past(dma_q[0]) && $past(tx_fifo_bytes) <= 5'h08
        |-> fifo_level_status[3:0] == $past(tx_fifo_bytes[3:0])) else $error("byte level wrong");
    a_half_units: assert property ($past(dma_q[0]) && $past(rx_fifo_bytes) <= 5'h10
        |-> fifo_level_status[11:8] == 4'(({1'b0, $past(rx_fifo_bytes)} + 6'h01) >> 1))
        else $error("half word level wrong");
    a_done_frame: assert property ($rose(xfer_done) |-> frame_end)
        else $error("done without frame end");
    a_done_stop: assert property ($rose(xfer_done) |-> ##[1:40] link_stop)
        else $error("link not stopped");
    a_slave_quiet: assert property (slave_q == 4'hF |-> !frame_end)
        else $error("frame in slave mode");
    a_write_clear: assert property (s_cnt_write |-> ##[1:2] !xfer_done)
        else $error("count write kept done");
    a_enable_clear: assert property (!port_enable [*2] |-> !xfer_done)
        else $error("disable kept done");
endmodule

bind spbc_core spbc_core_chk u_chk (.clock(clock), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .master_mode(master_mode), .port_enable(port_enable), .tx_fifo_bytes(tx_fifo_bytes),
    .rx_fifo_bytes(rx_fifo_bytes), .frame_end(frame_end), .xfer_done(xfer_done), .link_stop(link_stop),
    .fifo_level_status(fifo_level_status), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req),
    .tx_pad_byte(tx_pad_byte), .rx_discard_byte(rx_discard_byte));

`default_nettype wire

// ===== bench/spbc_shift_model.sv
// Shift engine model at the link's far side
`default_nettype none

module spbc_shift_model (
    // Control
    input wire logic nrst,
    input wire logic go,
    input wire logic slow,
    // Link
    input wire logic link_stop,
    output var logic link_clk,
    output var logic byte_shifted
);
    timeunit 1ns;
    timeprecision 100ps;

    int gap_q;

    // Link clock stands still while go is low
    initial
    begin
        link_clk = 1'b0;
        #3;
        forever
        begin
            if (go)
                #16 link_clk = ~link_clk;
            else
                @(go);
        end
    end

    // Byte every 2nd or 4th link cycle until stop
    always @(posedge link_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            byte_shifted <= 1'b0;
            gap_q <= 0;
        end
        else if (gap_q != 0)
        begin
            byte_shifted <= 1'b0;
            gap_q <= gap_q - 1;
        end
        else
        begin
            byte_shifted <= go && !link_stop;
            gap_q <= slow ? 3 : 1;
        end
    end
endmodule

`default_nettype wire

// ===== bench/spbc_core_tb.sv
// Bench for the byte count and DMA control block
`default_nettype none

module spbc_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import spbc_pkg::*;

    typedef struct packed {
        logic [15:0] cnt;
        logic multi;
        logic slow;
        logic [3:0] frames;
        logic done;
    } spbc_row_type;

    logic clock, nrst, ce, link_clk, byte_shifted, link_stop, go, slow, reg_wr, reg_rd, pad_seen;
    logic master_mode, multi_byte_frames, port_enable, frame_end, xfer_done;
    logic tx_dma_req, rx_dma_req, tx_pad_byte, rx_discard_byte;
    logic [31:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, fifo_level_status;
    logic [2:0] irq_threshold_field;
    logic [4:0] tx_fifo_bytes, rx_fifo_bytes;
    int failures, samples_checked, npulse, nb, frames;
    spbc_row_type rows [7];

    spbc_core dut (.*);

    spbc_shift_model partner (.nrst(nrst), .go(go), .slow(slow), .link_stop(link_stop), .link_clk(link_clk),
        .byte_shifted(byte_shifted));

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(negedge link_clk)
        if (byte_shifted === 1'b1)
            npulse++;

    always @(negedge clock)
        if (tx_pad_byte === 1'b1 && rx_discard_byte === 1'b1)
            pad_seen = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic hung;
        failures++;
        $display("ERROR %0t wait ran out", $time);
        final_report;
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [15:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        check(reg_rdata === e, "readback");
    endtask

    // Shifts until done, the wanted frame count, or ten bytes when want is zero
    task automatic run(input logic [3:0] want, input logic slow_i);
        int n;
        frames = 0;
        npulse = 0;
        pad_seen = 1'b0;
        @(posedge clock);
        slow <= slow_i;
        go <= 1'b1;
        for (n = 0; n < 600 && xfer_done !== 1'b1 && (want == 0 ? npulse < 10 : frames < want); n++)
        begin
            @(negedge clock);
            if (frame_end === 1'b1)
                frames++;
        end
        nb = npulse;
        if (n == 600)
            hung;
        for (n = 0; n < 60 && xfer_done === 1'b1 && link_stop !== 1'b1; n++)
            @(negedge clock);
        if (n == 60)
            hung;
        @(posedge clock);
        go <= 1'b0;
        @(negedge clock);
    endtask

    task automatic dma_case(input logic [15:0] d, input logic [4:0] tb, rb,
        input logic [2:0] th, input logic txr, rxr, input logic [7:0] lvl);
        @(posedge clock);
        tx_fifo_bytes <= tb;
        rx_fifo_bytes <= rb;
        irq_threshold_field <= th;
        wr(SPBC_DMA_ADDR, d);
        rd(SPBC_DMA_ADDR, d & 16'h0007);
        @(negedge clock);
        check(tx_dma_req === txr && rx_dma_req === rxr, "dma request");
        check(fifo_level_status === {4'h0, lvl[7:4], 4'h0, lvl[3:0]}, "fifo level");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #400000;
        hung;
    end

    initial
    begin
        {nrst, slow, reg_wr, reg_rd, reg_addr, reg_wdata, irq_threshold_field} = '0;
        {tx_fifo_bytes, rx_fifo_bytes, pad_seen, failures, samples_checked, npulse, nb, frames} = '0;
        {ce, master_mode, multi_byte_frames, port_enable, go} = 5'h1F;
        rows = '{'{16'h4003, 1'b1, 1'b0, 4'h1, 1'b1}, '{16'h0005, 1'b0, 1'b1, 4'h5, 1'b1},
            '{16'h8002, 1'b0, 1'b0, 4'h2, 1'b1}, '{16'h8002, 1'b1, 1'b0, 4'h3, 1'b0},
            '{16'h0000, 1'b1, 1'b1, 4'h0, 1'b0}, '{16'h8000, 1'b1, 1'b0, 4'h0, 1'b0},
            '{16'h0001, 1'b1, 1'b0, 4'h1, 1'b1}};
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        go <= 1'b0;
        foreach (rows[i])
        begin
            @(posedge clock);
            multi_byte_frames <= rows[i].multi;
            wr(SPBC_CNT_ADDR, rows[i].cnt);
            rd(SPBC_CNT_ADDR, rows[i].cnt & 16'hBFFF);
            run(rows[i].frames, rows[i].slow);
            check(xfer_done === rows[i].done, "done level");
            if (rows[i].frames != 4'h0)
                check(frames == rows[i].frames, "frame count");
            if (rows[i].done)
                check(nb == rows[i].cnt[13:0] && link_stop === 1'b1, "bytes at end");
            else
                check(link_stop === 1'b0, "transfer stopped");
            $display("row %0d ended", i);
        end
        @(posedge clock);
        master_mode <= 1'b0;
        wr(SPBC_CNT_ADDR, 16'h0002);
        run(4'h0, 1'b0);
        check(frames == 0 && xfer_done === 1'b0, "slave counted");
        @(posedge clock) master_mode <= 1'b1;
        $display("slave test ended");
        wr(SPBC_DMA_ADDR, 16'h0001);
        for (int c = 3; c < 5; c++)
        begin
            wr(SPBC_CNT_ADDR, 16'(c));
            run(4'h1, 1'b0);
            check(pad_seen === (c == 3), "odd count pad");
        end
        @(posedge clock);
        port_enable <= 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check(xfer_done === 1'b0, "disable kept done");
        @(posedge clock) port_enable <= 1'b1;
        $display("pad test ended");
        dma_case(16'hFFFF, 5'h03, 5'h02, 3'h0, 1'b1, 1'b1, 8'h12);
        dma_case(16'h0006, 5'h03, 5'h02, 3'h0, 1'b0, 1'b0, 8'h23);
        dma_case(16'h0003, 5'h10, 5'h02, 3'h0, 1'b0, 1'b0, 8'h18);
        dma_case(16'h0005, 5'h00, 5'h02, 3'h1, 1'b0, 1'b0, 8'h10);
        dma_case(16'h0005, 5'h00, 5'h01, 3'h0, 1'b0, 1'b1, 8'h10);
        dma_case(16'h0000, 5'h00, 5'h00, 3'h0, 1'b0, 1'b0, 8'h00);
        $display("dma test ended");
        wr(SPBC_CNT_ADDR, 16'h8005);
        @(posedge clock);
        nrst <= 1'b0;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        rd(SPBC_CNT_ADDR, 16'h0000);
        rd(SPBC_DMA_ADDR, 16'h0000);
        wr(32'h4005_4020, 16'hFFFF);
        rd(32'h4005_4020, 16'h0000);
        $display("reset test ended");
        final_report;
    end
endmodule

`default_nettype wire
